// File: common/ccsu_pkg.sv
// Constants and types shared by the capture/compare subunit files
package ccsu_pkg;
  // Counter and register widths
  localparam int CNT_W  = 16;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 3;

  // Register offsets on the plain register port
  localparam logic [2:0] ADDR_MODE   = 3'h0;
  localparam logic [2:0] ADDR_FLAGS  = 3'h1;
  localparam logic [2:0] ADDR_CC_LO  = 3'h2;
  localparam logic [2:0] ADDR_CC_HI  = 3'h3;
  localparam logic [2:0] ADDR_ENABLE = 3'h4;

  // Mode register field positions
  localparam int MODE_MASK_CAP = 7;
  localparam int MODE_MASK_CMP = 6;
  localparam int MODE_MASK_OVF = 5;
  localparam int MODE_FORCE    = 4;
  localparam int MODE_OUT_HI   = 3;
  localparam int MODE_OUT_LO   = 2;
  localparam int MODE_IN_HI    = 1;
  localparam int MODE_IN_LO    = 0;

  // Event flag register field positions
  localparam int FLAG_CAP    = 7;
  localparam int FLAG_CMP    = 6;
  localparam int FLAG_OVF    = 5;
  localparam int FLAG_LOCK   = 4;
  localparam int FLAG_PRESET = 3;

  // Values after reset, and the counter maximum
  localparam logic [7:0]  MODE_RESET = 8'h00;
  localparam logic [15:0] CC_RESET   = 16'hffff;
  localparam logic [15:0] CNT_RESET  = 16'h0000;
  localparam logic [15:0] CNT_MAX    = 16'hffff;

  // Output action modes
  localparam logic [1:0] OUT_OFF    = 2'h0;
  localparam logic [1:0] OUT_TOGGLE = 2'h1;
  localparam logic [1:0] OUT_LOW    = 2'h2;
  localparam logic [1:0] OUT_HIGH   = 2'h3;

  // Input action modes
  localparam logic [1:0] IN_NEVER = 2'h0;
  localparam logic [1:0] IN_RISE  = 2'h1;
  localparam logic [1:0] IN_FALL  = 2'h2;
  localparam logic [1:0] IN_BOTH  = 2'h3;

  // Capture flag states
  typedef enum logic [1:0] {
    CAPF_IDLE,
    CAPF_SET,
    CAPF_OVERRUN
  } ccsu_capf_e;
endpackage

// File: rtl/ccsu_sync.sv
// Two-stage synchroniser for the external event input
`timescale 1ns/1ps
module ccsu_sync (
  input  wire logic i_clk_sys,
  input  wire logic i_srst,
  input  wire logic i_async,
  output logic      o_sync
);
  logic meta;

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      meta   <= 1'b0;
      o_sync <= 1'b0;
    end else begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end
endmodule

// File: rtl/ccsu_cap_flag.sv
// Double-buffered capture event flag with an overrun state
`timescale 1ns/1ps
module ccsu_cap_flag (
  input  wire logic i_clk_sys,
  input  wire logic i_srst,
  input  wire logic i_set,
  input  wire logic i_clear,
  output logic      o_flag
);
  ccsu_pkg::ccsu_capf_e state;
  ccsu_pkg::ccsu_capf_e next_state;

  // A set in the same cycle as a clear is never lost
  always_comb begin
    next_state = state;
    case (state)
      ccsu_pkg::CAPF_IDLE: begin
        if (i_set) next_state = ccsu_pkg::CAPF_SET;
      end
      ccsu_pkg::CAPF_SET: begin
        if (i_set && !i_clear) next_state = ccsu_pkg::CAPF_OVERRUN;
        else if (!i_set && i_clear) next_state = ccsu_pkg::CAPF_IDLE;
      end
      ccsu_pkg::CAPF_OVERRUN: begin
        if (i_clear && !i_set) next_state = ccsu_pkg::CAPF_SET;
      end
      default: next_state = ccsu_pkg::CAPF_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) state <= ccsu_pkg::CAPF_IDLE;
    else state <= next_state;
  end

  assign o_flag = (state != ccsu_pkg::CAPF_IDLE);
endmodule

// File: rtl/ccsu_subunit.sv
// One capture/compare subunit with its counter, registers and actions
//
// What this block does
// - Compare low byte written first; matching held off until the high byte lands.
// - A compare match sets its flag, fires match interrupt, merged interrupt, output.
// - On match the output goes high, low, toggles or stays per mode.
// - Force bit holds output at the mode level (toggle mode toggles it every cycle), overriding compare events.
// - Input logic triggers independently: never, rising, falling or both edges.
// - Input trigger sets capture flag, merged interrupt, latches counter value.
// - Capture low byte read first; compare action locked until high byte read.
// - Lock-after-capture passes one capture, then locks until a mode write.
// - Capture-preset bit holds the capture register at all ones.
// - Counter overflow sets the overflow flag.
// - Masked capture, compare and overflow flags are ORed into merged interrupt.
// - Compare match also drives a separate unmaskable interrupt.
// - Interrupt sources run independently; writing one clears a flag.
// - Capture flag is double buffered; overrun needs two clearing writes.
// - Capture register holds the newest capture value while the capture-preset bit is clear.
// - Logic runs on the system clock; software avoids slow-mode flag writes.
// - Enable low puts the unit in standby with no event processing.
// - Mode and flag registers reset only by system reset, kept in standby.
// - Output modes: 00 off low, 01 toggle, 10 low, 11 high.
// - Input modes: 00 never, 01 rising, 10 falling, 11 both.
// - Standby holds counter at zero and resets capture and compare.
`timescale 1ns/1ps
module ccsu_subunit (
  input  wire logic       i_clk_sys,
  input  wire logic       i_srst,
  input  wire logic [2:0] i_addr,
  input  wire logic [7:0] i_wr_data,
  input  wire logic       i_wr_en,
  input  wire logic       i_rd_en,
  output logic      [7:0] o_rd_data,
  input  wire logic       i_count_tick,
  input  wire logic       i_event_in,
  output logic            o_action_out,
  output logic            o_match_irq,
  output logic            o_merged_irq
);
  // Output action for a trigger in the given mode
  function automatic logic act_level(input logic [1:0] sel, input logic cur);
    logic lvl;
    lvl = 1'b0;
    case (sel)
      ccsu_pkg::OUT_TOGGLE: lvl = ~cur;
      ccsu_pkg::OUT_HIGH:   lvl = 1'b1;
      default:              lvl = 1'b0;
    endcase
    return lvl;
  endfunction

  logic        enable;
  logic [7:0]  mode_reg;
  logic        lock_after_capture;
  logic        capture_preset_hold;
  logic        compare_event_flag;
  logic        overflow_event_flag;
  logic        capture_event_flag;
  logic [15:0] free_running_counter;
  logic [15:0] compare_value;
  logic [15:0] capture_value;
  logic [7:0]  capture_hi_latch;
  logic        cmp_wr_lock;
  logic        cap_rd_lock;
  logic        in_lock;
  logic        in_prev;
  logic        in_sync;

  // Address decoding
  wire sel_mode  = (i_addr == ccsu_pkg::ADDR_MODE);
  wire sel_flags = (i_addr == ccsu_pkg::ADDR_FLAGS);
  wire sel_cc_lo = (i_addr == ccsu_pkg::ADDR_CC_LO);
  wire sel_cc_hi = (i_addr == ccsu_pkg::ADDR_CC_HI);
  wire sel_en    = (i_addr == ccsu_pkg::ADDR_ENABLE);

  wire wr_mode  = i_wr_en & sel_mode;
  wire wr_flags = i_wr_en & sel_flags;
  wire wr_cc_lo = i_wr_en & sel_cc_lo & enable;
  wire wr_cc_hi = i_wr_en & sel_cc_hi & enable;
  wire wr_en    = i_wr_en & sel_en;
  wire rd_cc_lo = i_rd_en & sel_cc_lo & enable;
  wire rd_cc_hi = i_rd_en & sel_cc_hi & enable;

  // Mode fields
  wire [1:0] output_action_select = mode_reg[ccsu_pkg::MODE_OUT_HI:ccsu_pkg::MODE_OUT_LO];
  wire [1:0] input_action_select  = mode_reg[ccsu_pkg::MODE_IN_HI:ccsu_pkg::MODE_IN_LO];
  wire       force_out            = mode_reg[ccsu_pkg::MODE_FORCE];
  wire [2:0] mask_bits            = mode_reg[ccsu_pkg::MODE_MASK_CAP:ccsu_pkg::MODE_MASK_OVF];

  // Clearing writes
  wire clr_cap = wr_flags & i_wr_data[ccsu_pkg::FLAG_CAP];
  wire clr_cmp = wr_flags & i_wr_data[ccsu_pkg::FLAG_CMP];
  wire clr_ovf = wr_flags & i_wr_data[ccsu_pkg::FLAG_OVF];

  // Counter and compare
  wire [15:0] next_counter = 16'(free_running_counter + 16'h0001);
  wire        tick         = enable & i_count_tick;
  wire        overflow_evt = tick & (free_running_counter == ccsu_pkg::CNT_MAX);
  // Matching is blocked while a byte pair is half written or half read
  wire        match_evt    = tick & ~cmp_wr_lock & ~cap_rd_lock
                             & (next_counter == compare_value);

  // Input edge detection on the synchronised level
  wire rise = in_sync & ~in_prev;
  wire fall = ~in_sync & in_prev;
  wire trig_sel = ((input_action_select == ccsu_pkg::IN_RISE) & rise)
                | ((input_action_select == ccsu_pkg::IN_FALL) & fall)
                | ((input_action_select == ccsu_pkg::IN_BOTH) & (rise | fall));
  wire cap_evt  = enable & ~in_lock & trig_sel;

  // Output action
  wire next_action = !enable ? 1'b0 :
                     (output_action_select == ccsu_pkg::OUT_OFF) ? 1'b0 :
                     force_out ? act_level(output_action_select, o_action_out) :
                     match_evt ? act_level(output_action_select, o_action_out) :
                     o_action_out;

  // Interrupt and read data
  wire [2:0] flag_vec = {capture_event_flag, compare_event_flag, overflow_event_flag};
  wire       next_merged = |(flag_vec & mask_bits);
  wire [7:0] flags_rd = {capture_event_flag, compare_event_flag, overflow_event_flag,
                         lock_after_capture, capture_preset_hold, 3'h0};
  wire [7:0] next_rd_data = sel_mode  ? mode_reg :
                            sel_flags ? flags_rd :
                            sel_cc_lo ? capture_value[7:0] :
                            sel_cc_hi ? capture_hi_latch :
                            sel_en    ? {7'h00, enable} :
                            8'h00;

  ccsu_sync u_sync (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .i_async   (i_event_in),
    .o_sync    (in_sync)
  );

  ccsu_cap_flag u_cap_flag (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .i_set     (cap_evt),
    .i_clear   (clr_cap),
    .o_flag    (capture_event_flag)
  );

  // Registers kept through standby
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      enable              <= 1'b0;
      mode_reg            <= ccsu_pkg::MODE_RESET;
      lock_after_capture  <= 1'b0;
      capture_preset_hold <= 1'b0;
    end else begin
      if (wr_en) enable <= i_wr_data[0];
      if (wr_mode) mode_reg <= i_wr_data;
      if (wr_flags) begin
        lock_after_capture  <= i_wr_data[ccsu_pkg::FLAG_LOCK];
        capture_preset_hold <= i_wr_data[ccsu_pkg::FLAG_PRESET];
      end
    end
  end

  // Event flags: a set wins over a clear
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      compare_event_flag  <= 1'b0;
      overflow_event_flag <= 1'b0;
    end else begin
      compare_event_flag  <= match_evt | (compare_event_flag & ~clr_cmp);
      overflow_event_flag <= overflow_evt | (overflow_event_flag & ~clr_ovf);
    end
  end

  // Counter, compare and capture registers, reset by standby
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || !enable) begin
      free_running_counter <= ccsu_pkg::CNT_RESET;
      compare_value        <= ccsu_pkg::CC_RESET;
    end else begin
      if (i_count_tick) free_running_counter <= next_counter;
      if (wr_cc_lo) compare_value[7:0] <= i_wr_data;
      if (wr_cc_hi) compare_value[15:8] <= i_wr_data;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst || !enable || capture_preset_hold) begin
      capture_value <= ccsu_pkg::CC_RESET;
    end else if (cap_evt) begin
      capture_value <= free_running_counter;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst || !enable) capture_hi_latch <= ccsu_pkg::CC_RESET[15:8];
    else if (rd_cc_lo) capture_hi_latch <= capture_value[15:8];
  end

  // Byte-pair locks
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || !enable) begin
      cmp_wr_lock <= 1'b0;
      cap_rd_lock <= 1'b0;
    end else begin
      if (wr_cc_lo) cmp_wr_lock <= 1'b1;
      else if (wr_cc_hi) cmp_wr_lock <= 1'b0;
      if (rd_cc_lo) cap_rd_lock <= 1'b1;
      else if (rd_cc_hi) cap_rd_lock <= 1'b0;
    end
  end

  // Input lock: a capture in the same cycle as a mode write still locks
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      in_lock <= 1'b0;
      in_prev <= 1'b0;
    end else begin
      in_prev <= in_sync;
      if (cap_evt && lock_after_capture) in_lock <= 1'b1;
      else if (wr_mode) in_lock <= 1'b0;
    end
  end

  // Outputs
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_action_out <= 1'b0;
      o_match_irq  <= 1'b0;
      o_merged_irq <= 1'b0;
      o_rd_data    <= 8'h00;
    end else begin
      o_action_out <= next_action;
      o_match_irq  <= match_evt;
      o_merged_irq <= next_merged;
      o_rd_data    <= i_rd_en ? next_rd_data : 8'h00;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);

  sequence s_lo_write;
    wr_cc_lo;
  endsequence

  sequence s_lo_read;
    rd_cc_lo;
  endsequence

  sequence s_pin_rise;
    !in_sync ##1 in_sync;
  endsequence

  property p_cmp_wr_hold;
    s_lo_write |=> cmp_wr_lock && !match_evt;
  endproperty
  a_cmp_wr_hold: assert property (p_cmp_wr_hold) else $error("match during write lock");

  property p_cap_rd_hold;
    s_lo_read ##1 !rd_cc_hi |-> !match_evt;
  endproperty
  a_cap_rd_hold: assert property (p_cap_rd_hold) else $error("match during read lock");

  property p_match_irq;
    match_evt |=> o_match_irq && compare_event_flag;
  endproperty
  a_match_irq: assert property (p_match_irq) else $error("match not signalled");

  property p_toggle;
    match_evt && !force_out && output_action_select == ccsu_pkg::OUT_TOGGLE
      |=> o_action_out != $past(o_action_out);
  endproperty
  a_toggle: assert property (p_toggle) else $error("output did not toggle");

  property p_force_high;
    enable && force_out && output_action_select == ccsu_pkg::OUT_HIGH |=> o_action_out;
  endproperty
  a_force_high: assert property (p_force_high) else $error("force high failed");

  property p_capture;
    cap_evt && !capture_preset_hold |=> capture_value == $past(free_running_counter);
  endproperty
  a_capture: assert property (p_capture) else $error("capture value wrong");

  property p_lock_cap;
    cap_evt && lock_after_capture |=> in_lock && !cap_evt;
  endproperty
  a_lock_cap: assert property (p_lock_cap) else $error("input not locked");

  property p_preset;
    capture_preset_hold |=> capture_value == ccsu_pkg::CC_RESET;
  endproperty
  a_preset: assert property (p_preset) else $error("preset not held");

  property p_merged;
    compare_event_flag && mode_reg[ccsu_pkg::MODE_MASK_CMP] |=> o_merged_irq;
  endproperty
  a_merged: assert property (p_merged) else $error("merged interrupt missing");

  property p_standby;
    !enable |=> free_running_counter == ccsu_pkg::CNT_RESET && !o_action_out;
  endproperty
  a_standby: assert property (p_standby) else $error("standby not held");

  property p_overflow;
    overflow_evt |=> overflow_event_flag;
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow flag missing");

  property p_force_low;
    enable && force_out && output_action_select == ccsu_pkg::OUT_LOW |=> !o_action_out;
  endproperty
  a_force_low: assert property (p_force_low) else $error("force low failed");

  property p_drive_high;
    match_evt && !force_out && output_action_select == ccsu_pkg::OUT_HIGH |=> o_action_out;
  endproperty
  a_drive_high: assert property (p_drive_high) else $error("match high failed");

  property p_rise_capture;
    s_pin_rise ##0 (enable && !in_lock && input_action_select == ccsu_pkg::IN_RISE)
      |=> capture_event_flag;
  endproperty
  a_rise_capture: assert property (p_rise_capture) else $error("rise not captured");

  property p_cap_flag;
    cap_evt |=> capture_event_flag;
  endproperty
  a_cap_flag: assert property (p_cap_flag) else $error("capture flag missing");

  property p_mode_unlock;
    wr_mode && !(cap_evt && lock_after_capture) |=> !in_lock;
  endproperty
  a_mode_unlock: assert property (p_mode_unlock) else $error("lock not released");

  property p_merged_cap;
    capture_event_flag && mode_reg[ccsu_pkg::MODE_MASK_CAP] |=> o_merged_irq;
  endproperty
  a_merged_cap: assert property (p_merged_cap) else $error("capture not merged");

  property p_merged_ovf;
    overflow_event_flag && mode_reg[ccsu_pkg::MODE_MASK_OVF] |=> o_merged_irq;
  endproperty
  a_merged_ovf: assert property (p_merged_ovf) else $error("overflow not merged");

  // Standby freezes the flags; only a clearing write may move them
  property p_stby_flags;
    !enable && !wr_flags |=> $stable(compare_event_flag) && $stable(overflow_event_flag)
      && $stable(capture_event_flag);
  endproperty
  a_stby_flags: assert property (p_stby_flags) else $error("standby flag change");
endmodule

// File: sim/ccsu_ext_model.sv
// Far-side model: external event source and interrupt controller tally
`timescale 1ns/1ps
module ccsu_ext_model (
  input  wire logic i_clk_sys,
  input  wire logic i_match_irq,
  output logic      o_event_in,
  output int        o_match_cnt
);
  int cnt = 0;

  assign o_match_cnt = cnt;

  initial begin
    o_event_in = 1'b0;
  end

  // Pin moves off the clock grid, as an unrelated source would
  task automatic drive(input logic v);
    #7;
    o_event_in = v;
  endtask

  // Each one-cycle match pulse is one interrupt request
  always @(posedge i_clk_sys) begin
    if (i_match_irq === 1'b1) begin
      cnt <= cnt + 1;
    end
  end
endmodule

// File: sim/tb_top.sv
// Self-checking bench for the capture/compare subunit
`timescale 1ns/1ps
module tb_top;
  logic        clk   = 1'b0;
  logic        srst  = 1'b1;
  logic [2:0]  addr  = 3'h0;
  logic [7:0]  wdata = 8'h00;
  logic        wen   = 1'b0;
  logic        ren   = 1'b0;
  logic        tck   = 1'b0;
  logic [7:0]  rdata;
  logic        ev;
  logic        act;
  logic        mirq;
  logic        girq;
  int          mcnt;
  int          error_cnt    = 0;
  int          total_checks = 0;
  int          cyc          = 0;
  int          ref_cnt      = 0;
  int          cmp_m        = 65535;
  int          exp_m        = 0;
  int          mode_m       = 0;
  logic        pin_m        = 1'b0;
  logic [15:0] lf           = 16'h99f4;
  int          om[5]        = '{3, 1, 1, 2, 0};
  int          cap_q[$];

  ccsu_subunit DUT (
    .i_clk_sys    (clk),
    .i_srst       (srst),
    .i_addr       (addr),
    .i_wr_data    (wdata),
    .i_wr_en      (wen),
    .i_rd_en      (ren),
    .o_rd_data    (rdata),
    .i_count_tick (tck),
    .i_event_in   (ev),
    .o_action_out (act),
    .o_match_irq  (mirq),
    .o_merged_irq (girq)
  );

  ccsu_ext_model ext (
    .i_clk_sys   (clk),
    .i_match_irq (mirq),
    .o_event_in  (ev),
    .o_match_cnt (mcnt)
  );

  always #12.5 clk = ~clk;

  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      error_cnt++;
      results();
    end
  end

  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic done(input string nm);
    $display("Test %s finished", nm);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One write strobe, then a quiet edge before the next access
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr  <= a;
    wdata <= d;
    wen   <= 1'b1;
    @(posedge clk);
    wen   <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    addr <= a;
    ren  <= 1'b1;
    @(posedge clk);
    ren  <= 1'b0;
    #1;
    d = rdata;
    @(posedge clk);
  endtask

  task automatic cf(input string nm, input logic [7:0] e);
    logic [7:0] d;
    rd(ccsu_pkg::ADDR_FLAGS, d);
    chk(nm, 16'(d), 16'(e));
  endtask

  task automatic rcap(output logic [15:0] v);
    rd(ccsu_pkg::ADDR_CC_LO, v[7:0]);
    rd(ccsu_pkg::ADDR_CC_HI, v[15:8]);
  endtask

  task automatic setm(input int m);
    wr(ccsu_pkg::ADDR_MODE, 8'(m));
    mode_m = m;
    if (m[3:2] == 0) pin_m = 1'b0;
    if (m[4]) pin_m = (m[3:2] == 3);
  endtask

  task automatic setc(input int v);
    wr(ccsu_pkg::ADDR_CC_LO, 8'(v));
    wr(ccsu_pkg::ADDR_CC_HI, 8'(v >> 8));
    cmp_m = v;
  endtask

  // Counter model; lk marks a span where compare action is held off
  task automatic tick(input int n, input bit lk);
    repeat (n) begin
      tck <= 1'b1;
      @(posedge clk);
      ref_cnt = (ref_cnt + 1) % 65536;
      if (ref_cnt == cmp_m && !lk) begin
        exp_m++;
        if (!mode_m[4]) pin_m = (mode_m[3:2] == 1) ? !pin_m : (mode_m[3:2] == 3);
      end
    end
    tck <= 1'b0;
    @(posedge clk);
  endtask

  task automatic edge_ev(input logic v, input bit hit);
    ext.drive(v);
    idle(6);
    if (hit) cap_q.push_back(ref_cnt);
  endtask

  task automatic results();
    $display("Checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    logic [7:0]  d;
    logic [15:0] c;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(ccsu_pkg::ADDR_MODE, d);
    chk("mode reset", 16'(d), 16'h0000);
    cf("flags reset", 8'h00);
    rcap(c);
    chk("cc reset", c, ccsu_pkg::CC_RESET);
    rd(3'h7, d);
    chk("unmapped", 16'(d), 16'h0000);
    chk("pin reset", 16'(act), 16'h0000);
    done("reset");
    wr(ccsu_pkg::ADDR_ENABLE, 8'h01);
    for (int i = 0; i < 5; i++) begin
      lf = nx(lf);
      setm(32'h40 | (om[i] << 2));
      setc(ref_cnt + 2 + int'(lf[2:0]));
      tick(12, 0);
      idle(2);
      chk("match pulses", 16'(mcnt), 16'(exp_m));
      chk("pin", 16'(act), 16'(pin_m));
      cf("cmp flag", 8'h40);
      chk("merged cmp", 16'(girq), 16'h0001);
      wr(ccsu_pkg::ADDR_FLAGS, 8'h40);
    end
    setc(ref_cnt + 3);
    wr(ccsu_pkg::ADDR_CC_LO, 8'(cmp_m));
    tick(5, 1);
    wr(ccsu_pkg::ADDR_CC_HI, 8'(cmp_m >> 8));
    setc(ref_cnt + 3);
    rd(ccsu_pkg::ADDR_CC_LO, d);
    tick(5, 1);
    rd(ccsu_pkg::ADDR_CC_HI, d);
    idle(2);
    chk("locked pulses", 16'(mcnt), 16'(exp_m));
    setm(32'h1c);
    idle(2);
    chk("force high", 16'(act), 16'h0001);
    setm(32'h18);
    idle(2);
    chk("force low", 16'(act), 16'h0000);
    setm(32'h0c); // Force only pulsed, never with toggle
    done("compare");
    for (int m = 0; m < 4; m++) begin
      setm(32'h80 | m); // Input held still while reprogrammed
      edge_ev(1'b1, m[0]);
      cf("rise", {m[0], 7'h00});
      chk("merged cap", 16'(girq), 16'(m[0]));
      wr(ccsu_pkg::ADDR_FLAGS, 8'h80);
      tick(1, 0);
      edge_ev(1'b0, m[1]);
      cf("fall", {m[1], 7'h00});
      wr(ccsu_pkg::ADDR_FLAGS, 8'h80);
      tick(1, 0);
    end
    rcap(c);
    chk("capture", c, 16'(cap_q[$]));
    setm(32'h83);
    edge_ev(1'b1, 1);
    tick(2, 0);
    edge_ev(1'b0, 1);
    wr(ccsu_pkg::ADDR_FLAGS, 8'h80); // Clear, read back, repeat on overrun
    cf("overrun", 8'h80);
    wr(ccsu_pkg::ADDR_FLAGS, 8'h80);
    cf("cleared", 8'h00);
    rcap(c);
    chk("latest", c, 16'(cap_q[$]));
    wr(ccsu_pkg::ADDR_FLAGS, 8'h10);
    edge_ev(1'b1, 1);
    wr(ccsu_pkg::ADDR_FLAGS, 8'h90);
    tick(1, 0);
    edge_ev(1'b0, 0);
    cf("locked", 8'h10);
    setm(32'h83); // Same value rewritten to unlock
    edge_ev(1'b1, 1);
    cf("unlocked", 8'h90);
    rcap(c);
    chk("lac capture", c, 16'(cap_q[$]));
    wr(ccsu_pkg::ADDR_FLAGS, 8'h88);
    rcap(c);
    chk("preset", c, 16'hffff);
    wr(ccsu_pkg::ADDR_FLAGS, 8'h00);
    done("capture");
    setm(32'h3c);
    tick(65536 - ref_cnt, 0);
    idle(2);
    cf("overflow", 8'h20);
    chk("merged ovf", 16'(girq), 16'h0001);
    chk("wrap pulses", 16'(mcnt), 16'(exp_m));
    chk("force pin", 16'(act), 16'(pin_m));
    wr(ccsu_pkg::ADDR_ENABLE, 8'h00);
    tick(3, 1);
    ref_cnt = 0;
    chk("standby pin", 16'(act), 16'h0000);
    rd(ccsu_pkg::ADDR_MODE, d);
    chk("mode kept", 16'(d), 16'h003c);
    cf("flags kept", 8'h20);
    rcap(c);
    chk("cc standby", c, 16'hffff);
    wr(ccsu_pkg::ADDR_ENABLE, 8'h01);
    setm(32'h2c); // Force released after its pulse
    wr(ccsu_pkg::ADDR_FLAGS, 8'h20);
    setc(2);
    tick(2, 0);
    idle(2);
    chk("restart match", 16'(mcnt), 16'(exp_m));
    chk("restart pin", 16'(act), 16'(pin_m));
    chk("merged masked", 16'(girq), 16'h0000);
    done("standby");
    results();
  end
endmodule
